// ==== rtl/aud_converter_control.sv ====
// audio converter control: output (dac) and input (adc) paths with apb regs
// assumes single-cycle ack strobes from dma and adc, synchronous to mclk
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module aud_converter_control
    import aud_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             outDmaReq,
    input  wire aud_sample_t outDmaIn,
    input  wire logic        outPageOne,
    input  wire logic        outPageTwo,
    output aud_sample_t      dacOut,
    output logic             dacRefEnable,
    output logic             inDmaReq,
    input  wire logic        inDmaAck,
    output logic      [9:0]  inDmaData,
    input  wire logic        inPageOne,
    input  wire logic        inPageTwo,
    output logic             adcReq,
    input  wire aud_sample_t adcIn,
    output logic             adcRefEnable
);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] regAddr(input logic [31:0] idx);
        return {idx[29:0], 2'b00};
    endfunction : regAddr

    // rate decode; reserved codes fall back to the slowest rate
    function automatic logic [11:0] ratePeriod(input logic [2:0] code);
        case (code)
            AUD_RATE_11K: return 12'(AUD_PER_11K_CYC);
            AUD_RATE_22K: return 12'(AUD_PER_22K_CYC);
            AUD_RATE_44K: return 12'(AUD_PER_44K_CYC);
            default:      return 12'(AUD_PER_8K_CYC);
        endcase
    endfunction : ratePeriod

    ////////////////////////////////////////////////////////////////////////
    // state
    logic        softRst, inEnReg, outEnReg;
    logic [15:0] flags;
    logic        outStop, inStop;
    logic [2:0]  outRate, inRate;
    logic [9:0]  outHold, outStage, inHold, inStage;
    logic        outHoldValid, outStageValid, inHoldValid, inStageValid;
    logic        muteArmed;
    logic [11:0] outCnt, inCnt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire         access  = psel & penable;
    wire         setup   = psel & ~penable;
    wire         wrEn    = access & pwrite;
    wire         hitEn   = paddr == regAddr(AUD_IDX_ENABLE);
    wire         hitInt  = paddr == regAddr(AUD_IDX_INTFLAGS);
    wire         hitVal  = paddr == regAddr(AUD_IDX_VALID);
    wire         hitOCt  = paddr == regAddr(AUD_IDX_OUT_CTRL);
    wire         hitORt  = paddr == regAddr(AUD_IDX_OUT_RATE);
    wire         hitICt  = paddr == regAddr(AUD_IDX_IN_CTRL);
    wire         hitIRt  = paddr == regAddr(AUD_IDX_IN_RATE);
    wire         hitOHd  = paddr == regAddr(AUD_IDX_OUT_HOLD);
    wire         hitOSt  = paddr == regAddr(AUD_IDX_OUT_STAGE);
    wire         hitIHd  = paddr == regAddr(AUD_IDX_IN_HOLD);
    wire         hitISt  = paddr == regAddr(AUD_IDX_IN_STAGE);
    wire         mapped  = hitEn | hitInt | hitVal | hitOCt | hitORt |
                           hitICt | hitIRt | hitOHd | hitOSt | hitIHd | hitISt;
    wire [15:0]  wdata   = pwdata[15:0];

    // soft reset gates both path enables
    wire         outEn   = outEnReg & ~softRst;
    wire         inEn    = inEnReg & ~softRst;
    // a cleared enable holds its path in reset
    wire         outRst  = srst | ~outEn;
    wire         inRst   = srst | ~inEn;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    wire [15:0] rdMux =
        hitEn  ? {softRst, 10'h000, inEnReg, 3'h0, outEnReg} :
        hitInt ? flags :
        hitVal ? {12'h000, outHoldValid, outStageValid,
                  inHoldValid, inStageValid} :
        hitOCt ? {dacRefEnable, 11'h000, outEn, 1'b0, outStop, 1'b0} :
        hitORt ? {13'h0000, outRate} :
        hitICt ? {adcRefEnable, 11'h000, inEn, 1'b0, inStop, adcReq} :
        hitIRt ? {13'h0000, inRate} :
        hitOHd ? {6'h00, outHold} :
        hitOSt ? {6'h00, outStage} :
        hitIHd ? {6'h00, inHold} :
        hitISt ? {6'h00, inStage} : 16'h0000;

    // read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge mclk)
    begin
        if (srst)
            prdata <= 32'h00000000;
        else if (setup & ~pwrite)
            prdata <= {16'h0000, rdMux};
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            softRst      <= 1'b0;
            inEnReg      <= 1'b0;
            outEnReg     <= 1'b0;
            dacRefEnable <= 1'b0;
            adcRefEnable <= 1'b0;
            outStop      <= 1'b0;
            inStop       <= 1'b0;
            outRate      <= AUD_RATE_RESET;
            inRate       <= AUD_RATE_RESET;
        end
        else
        begin
            if (wrEn & hitEn)
            begin
                softRst  <= wdata[AUD_EN_SOFT_RST];
                inEnReg  <= wdata[AUD_EN_IN];
                outEnReg <= wdata[AUD_EN_OUT];
            end
            if (wrEn & hitOCt)
            begin
                dacRefEnable <= wdata[AUD_CT_REF];
                outStop      <= wdata[AUD_CT_STOP];
            end
            if (wrEn & hitICt)
            begin
                adcRefEnable <= wdata[AUD_CT_REF];
                inStop       <= wdata[AUD_CT_STOP];
            end
            if (wrEn & hitORt)
                outRate <= wdata[2:0];
            if (wrEn & hitIRt)
                inRate <= wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pacing counters
    // settling is always added: hardware cannot see whether software waited
    // settle plus one period before first tick
    wire [11:0] outStart = 12'(AUD_SETTLE_CYC) + ratePeriod(outRate) - 12'h001;
    wire [11:0] inStart  = 12'(AUD_SETTLE_CYC) + ratePeriod(inRate) - 12'h001;
    wire        outTick  = outEn & (outCnt == 12'h000);
    wire        inTick   = inEn & (inCnt == 12'h000);

    // counter runs on enable alone, dma or not
    always_ff @(posedge mclk)
    begin
        if (outRst)
            outCnt <= outStart;
        else if (outTick)
            outCnt <= ratePeriod(outRate) - 12'h001;
        else
            outCnt <= outCnt - 12'h001;
    end

    always_ff @(posedge mclk)
    begin
        if (inRst)
            inCnt <= inStart;
        else if (inTick)
            inCnt <= ratePeriod(inRate) - 12'h001;
        else
            inCnt <= inCnt - 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // output path
    // page stop blocks requests until the flag is cleared
    wire outStopped = outStop ? flags[AUD_FL_OUT_ONE] : flags[AUD_FL_OUT_TWO];
    assign outDmaReq = outEn & ~outStageValid & ~outStopped;
    wire   outAck    = outDmaIn.strobe & outDmaReq;
    wire   outShift  = outTick & outHoldValid;
    wire   muteEvt   = outTick & ~outHoldValid & muteArmed;

    always_ff @(posedge mclk)
    begin
        // disabled path returns to mid-scale, invalid
        if (outRst)
        begin
            outHold       <= AUD_MID_SCALE;
            outStage      <= AUD_MID_SCALE;
            outHoldValid  <= 1'b0;
            outStageValid <= 1'b0;
        end
        else
        begin
            // debug writes are the only other way to set valid
            if (wrEn & hitOHd)
                outHold <= wdata[9:0];
            if (wrEn & hitOSt)
                outStage <= wdata[9:0];
            if (wrEn & hitVal)
            begin
                outHoldValid  <= wdata[AUD_DV_OUT_HOLD];
                outStageValid <= wdata[AUD_DV_OUT_STAGE];
            end
            // shift staging into holding on each tick that finds holding valid
            if (outShift)
            begin
                if (outStageValid)
                begin
                    outHold       <= outStage;
                    outStageValid <= 1'b0;
                end
                else if (outAck)
                    outHold <= outDmaIn.data;
                outHoldValid <= outStageValid | outAck;
            end
            // ack fills holding first, then staging
            else if (outAck)
            begin
                if (outHoldValid)
                begin
                    outStage      <= outDmaIn.data;
                    outStageValid <= 1'b1;
                end
                else
                begin
                    outHold      <= outDmaIn.data;
                    outHoldValid <= 1'b1;
                end
            end
        end
    end

    // arm mute after enable once holding has gone valid
    always_ff @(posedge mclk)
    begin
        if (outRst)
            muteArmed <= 1'b0;
        else if (outHoldValid)
            muteArmed <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            dacOut <= '{strobe: 1'b0, data: AUD_MID_SCALE};
        else
        begin
            dacOut.strobe <= outShift;
            if (outShift)
                dacOut.data <= outHold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input path
    wire inStopped = inStop ? flags[AUD_FL_IN_ONE] : flags[AUD_FL_IN_TWO];
    wire adcAck    = adcIn.strobe & adcReq;
    wire inMove    = inHoldValid & ~inStageValid;
    // overwrite of a valid holding word while staging is still valid is a loss
    wire lossEvt   = adcAck & inHoldValid & ~inMove;
    assign inDmaReq  = inEn & inStageValid & ~inStopped;
    assign inDmaData = inStage;
    wire   inAck     = inDmaAck & inDmaReq;

    // one request per tick, held until the converter answers
    always_ff @(posedge mclk)
    begin
        if (inRst)
            adcReq <= 1'b0;
        else if (inTick)
            adcReq <= 1'b1;
        else if (adcAck)
            adcReq <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        // disabled path returns to mid-scale, invalid
        if (inRst)
        begin
            inHold       <= AUD_MID_SCALE;
            inStage      <= AUD_MID_SCALE;
            inHoldValid  <= 1'b0;
            inStageValid <= 1'b0;
        end
        else
        begin
            if (wrEn & hitIHd)
                inHold <= wdata[9:0];
            if (wrEn & hitISt)
                inStage <= wdata[9:0];
            if (wrEn & hitVal)
            begin
                inHoldValid  <= wdata[AUD_DV_IN_HOLD];
                inStageValid <= wdata[AUD_DV_IN_STAGE];
            end
            // move holding to staging, dma ack empties staging
            if (inMove)
            begin
                inStage      <= inHold;
                inStageValid <= 1'b1;
                inHoldValid  <= 1'b0;
            end
            else if (inAck)
                inStageValid <= 1'b0;
            if (adcAck)
            begin
                inHold      <= adcIn.data;
                inHoldValid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags
    wire [15:0] setVec;
    assign setVec[15:12]          = 4'h0;
    assign setVec[AUD_FL_IN_TWO]  = inEn & inPageTwo;
    assign setVec[AUD_FL_IN_ONE]  = inEn & inPageOne;
    assign setVec[AUD_FL_IN_LOSS] = lossEvt;
    assign setVec[AUD_FL_IN_DONE] = inRst ? 1'b0 : inMove;
    assign setVec[7:4]            = 4'h0;
    assign setVec[AUD_FL_OUT_TWO] = outEn & outPageTwo;
    assign setVec[AUD_FL_OUT_ONE] = outEn & outPageOne;
    assign setVec[AUD_FL_OUT_MUTE] = muteEvt;
    assign setVec[0]              = 1'b0;
    wire [15:0] clrVec = (wrEn & hitInt) ? wdata & AUD_FLAG_MASK : 16'h0000;

    // write one clears, a same-cycle event wins
    always_ff @(posedge mclk)
    begin
        if (srst | softRst)
            flags <= 16'h0000;
        else
            flags <= ((flags & ~clrVec) | setVec) & AUD_FLAG_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_soft_rst;
        softRst |=> !outHoldValid && !inHoldValid && !adcReq && flags == 0;
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft reset did not clear path state");

    // request drops at once; storage clears on the following edge
    property p_out_off;
        !outEn |-> !outDmaReq ##1 (!outHoldValid && !outStageValid
                                   && outHold == AUD_MID_SCALE);
    endproperty
    a_out_off: assert property (p_out_off)
        else $error("disabled output path still holds data");

    property p_in_off;
        !inEnReg |=> !inHoldValid && !inStageValid
                     && inStage == AUD_MID_SCALE && !adcReq;
    endproperty
    a_in_off: assert property (p_in_off)
        else $error("disabled input path still holds data");

    property p_w1c;
        wrEn && hitInt && wdata[AUD_FL_IN_LOSS] && !lossEvt
        |=> !flags[AUD_FL_IN_LOSS];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear flag");

    property p_loss;
        lossEvt |=> flags[AUD_FL_IN_LOSS] && inHoldValid
                    && inHold == $past(adcIn.data);
    endproperty
    a_loss: assert property (p_loss)
        else $error("data loss not flagged or not overwritten");

    property p_done;
        $rose(inStageValid) && !$past(wrEn) |-> flags[AUD_FL_IN_DONE];
    endproperty
    a_done: assert property (p_done)
        else $error("staging load without receive done");

    property p_mute;
        outTick && !outHoldValid && muteArmed |=> flags[AUD_FL_OUT_MUTE];
    endproperty
    a_mute: assert property (p_mute)
        else $error("empty tick did not raise mute");

    property p_arm;
        $rose(flags[AUD_FL_OUT_MUTE]) |-> $past(muteArmed) && $past(outEn);
    endproperty
    a_arm: assert property (p_arm)
        else $error("mute raised before arming");

    property p_dac;
        outTick && outHoldValid |=> dacOut.strobe
                                    && dacOut.data == $past(outHold);
    endproperty
    a_dac: assert property (p_dac)
        else $error("holding word not sent to converter");

    property p_adc_once;
        $rose(adcReq) |-> $past(inTick);
    endproperty
    a_adc_once: assert property (p_adc_once)
        else $error("conversion request outside interval");

    property p_start;
        $rose(outEn) |-> outCnt == outStart ##1 !outTick [*8];
    endproperty
    a_start: assert property (p_start)
        else $error("output start delay not loaded");

    property p_page;
        outEn && outStop && outPageOne |=> !outDmaReq;
    endproperty
    a_page: assert property (p_page)
        else $error("dma request during page stop");

    c_mute:  cover property (muteEvt);
    c_loss:  cover property (lossEvt);
    c_shift: cover property (outShift && outStageValid);
    c_stop:  cover property (inEn && inStageValid && inStopped);

endmodule : aud_converter_control

// ==== rtl/aud_pkg.sv ====
// constants, register map and carrier types of the audio converter control
// assumes a single 25 MHz system clock and 32-bit apb register access
package aud_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int AUD_CLK_HZ        = 25_000_000;
    localparam int AUD_CLK_PERIOD_NS = 40;
    localparam int AUD_SETTLE_NS     = 5000;
    // least time: round up to whole cycles
    localparam int AUD_SETTLE_CYC    =
        (AUD_SETTLE_NS + AUD_CLK_PERIOD_NS - 1) / AUD_CLK_PERIOD_NS;
    localparam int AUD_RATE_11K_HZ   = 11025;
    localparam int AUD_RATE_22K_HZ   = 22050;
    localparam int AUD_RATE_44K_HZ   = 44100;
    localparam int AUD_RATE_8K_HZ    = 8000;
    localparam int AUD_PER_11K_CYC   = AUD_CLK_HZ / AUD_RATE_11K_HZ;
    localparam int AUD_PER_22K_CYC   = AUD_CLK_HZ / AUD_RATE_22K_HZ;
    localparam int AUD_PER_44K_CYC   = AUD_CLK_HZ / AUD_RATE_44K_HZ;
    localparam int AUD_PER_8K_CYC    = AUD_CLK_HZ / AUD_RATE_8K_HZ;

    ////////////////////////////////////////////////////////////////////////
    // sample rate codes
    localparam logic [2:0] AUD_RATE_11K = 3'h0;
    localparam logic [2:0] AUD_RATE_22K = 3'h1;
    localparam logic [2:0] AUD_RATE_44K = 3'h2;
    localparam logic [2:0] AUD_RATE_8K  = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [31:0] AUD_IDX_IN_STAGE  = 32'h0B000160;
    localparam logic [31:0] AUD_IDX_OUT_STAGE = 32'h0B000162;
    localparam logic [31:0] AUD_IDX_OUT_HOLD  = 32'h0B000166;
    localparam logic [31:0] AUD_IDX_OUT_CTRL  = 32'h0B000168;
    localparam logic [31:0] AUD_IDX_OUT_RATE  = 32'h0B00016A;
    localparam logic [31:0] AUD_IDX_IN_HOLD   = 32'h0B000170;
    localparam logic [31:0] AUD_IDX_IN_CTRL   = 32'h0B000172;
    localparam logic [31:0] AUD_IDX_IN_RATE   = 32'h0B000174;
    localparam logic [31:0] AUD_IDX_VALID     = 32'h0B000178;
    localparam logic [31:0] AUD_IDX_ENABLE    = 32'h0B00017A;
    localparam logic [31:0] AUD_IDX_INTFLAGS  = 32'h0B00017C;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int AUD_EN_SOFT_RST   = 15;
    localparam int AUD_EN_IN         = 4;
    localparam int AUD_EN_OUT        = 0;
    localparam int AUD_FL_IN_TWO     = 11;
    localparam int AUD_FL_IN_ONE     = 10;
    localparam int AUD_FL_IN_LOSS    = 9;
    localparam int AUD_FL_IN_DONE    = 8;
    localparam int AUD_FL_OUT_TWO    = 3;
    localparam int AUD_FL_OUT_ONE    = 2;
    localparam int AUD_FL_OUT_MUTE   = 1;
    localparam int AUD_CT_REF        = 15;
    localparam int AUD_CT_STATE      = 3;
    localparam int AUD_CT_STOP       = 1;
    localparam int AUD_CT_ADC_REQ    = 0;
    localparam int AUD_DV_OUT_HOLD   = 3;
    localparam int AUD_DV_OUT_STAGE  = 2;
    localparam int AUD_DV_IN_HOLD    = 1;
    localparam int AUD_DV_IN_STAGE   = 0;

    ////////////////////////////////////////////////////////////////////////
    // flag mask and reset values
    localparam logic [15:0] AUD_FLAG_MASK  = 16'h0F0E;
    localparam logic [9:0]  AUD_MID_SCALE  = 10'h200;
    localparam logic [2:0]  AUD_RATE_RESET = 3'h0;

    // one sample word with its strobe
    typedef struct packed {
        logic       strobe;
        logic [9:0] data;
    } aud_sample_t;

endpackage : aud_pkg

// ==== sim/aud_far_model.sv ====
// far side model: dma controller and adc converter answering requests
// assumes requests are levels sampled at the mclk rising edge
`timescale 1ns/10ps
module aud_far_model
    import aud_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        outDmaReq,
    output aud_sample_t      outDmaIn,
    input  wire logic        inDmaReq,
    output logic             inDmaAck,
    input  wire logic        adcReq,
    output aud_sample_t      adcIn
);
    // one word per ack, a cycle after the request is seen
    always_ff @(posedge mclk)
    begin
        outDmaIn <= '{outDmaReq & !outDmaIn.strobe, 10'($urandom)};
        inDmaAck <= inDmaReq & !inDmaAck;
    end

    // ack with result; data changes every cycle outside the ack
    always_ff @(posedge mclk)
    begin
        adcIn <= '{adcReq & !adcIn.strobe, 10'($urandom)};
    end
endmodule : aud_far_model

// ==== sim/aud_converter_control_tb.sv ====
// bench for the audio converter control: apb, rate, flag and reset tests
// assumes aud_far_model answers the dma and adc requests
`timescale 1ns/10ps
module aud_converter_control_tb;
    import aud_pkg::*;
    logic        mclk, srst, psel, penable, pwrite, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        pready, pslverr, outDmaReq, inDmaReq, inDmaAck, adcReq;
    logic [9:0]  inDmaData, lastAdc;
    logic [9:0]  q[$];
    logic [3:0]  pg, pv;
    logic [1:0]  refEn;
    aud_sample_t outDmaIn, dacOut, adcIn;
    int          failures, n_compared, n, d;
    int          per[4] = '{AUD_PER_11K_CYC, AUD_PER_22K_CYC,
                            AUD_PER_44K_CYC, AUD_PER_8K_CYC};
    logic [2:0]  code[4] = '{AUD_RATE_11K, AUD_RATE_22K, AUD_RATE_44K,
                             AUD_RATE_8K};

    aud_converter_control dut (.mclk(mclk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .outDmaReq(outDmaReq), .outDmaIn(outDmaIn), .outPageOne(pg[0]),
        .outPageTwo(pg[1]), .dacOut(dacOut), .dacRefEnable(refEn[0]),
        .inDmaReq(inDmaReq), .inDmaAck(inDmaAck), .inDmaData(inDmaData),
        .inPageOne(pg[2]), .inPageTwo(pg[3]), .adcReq(adcReq),
        .adcIn(adcIn), .adcRefEnable(refEn[1]));
    aud_far_model far (.mclk(mclk), .outDmaReq(outDmaReq),
        .outDmaIn(outDmaIn), .inDmaReq(inDmaReq), .inDmaAck(inDmaAck),
        .adcReq(adcReq), .adcIn(adcIn));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bail();
        failures++;
        $display("MISMATCH %0t wait limit", $time);
        final_report();
    endtask : bail

    // idle edge first, so psel is never set twice in one step
    task automatic apb(input logic [31:0] idx, input logic w,
                       input logic [31:0] v);
        int k;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= idx << 2;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
            if (k > 50)
                bail();
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic waitStrobe();
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
            if (n > 4000)
                bail();
        end
        while (dacOut.strobe !== 1'b1);
    endtask : waitStrobe

    // words leave for the converter in the order dma delivered them
    always @(posedge mclk)
    begin
        if (dacOut.strobe === 1'b1)
            chk(dacOut.data, q.pop_front());
        if (outDmaIn.strobe && outDmaReq)
            q.push_back(outDmaIn.data);
        if (adcIn.strobe && adcReq)
            lastAdc <= adcIn.data;
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever
            #20 mclk = ~mclk;
    end

    initial
    begin
        failures = 0;
        n_compared = 0;
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pg} = '0;
        void'($urandom(28182));
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        apb(AUD_IDX_ENABLE, 1'b0, 0);
        chk(rd, 0);
        apb(32'h0B000100, 1'b0, 32'hFFFFFFFF);
        chk(32'(err), 1);
        chk(rd, 0);
        $display("reset and unmapped test done");
        // reference on before the path is enabled
        apb(AUD_IDX_OUT_CTRL, 1'b1, 32'h00008000);
        for (int i = 0; i < 4; i++)
        begin
            apb(AUD_IDX_OUT_RATE, 1'b1, 32'(code[i]));
            apb(AUD_IDX_ENABLE, 1'b1, 32'h00000001);
            waitStrobe();
            d = n - AUD_SETTLE_CYC - per[i];
            chk(32'(d >= 0 && d <= 3), 1);
            waitStrobe();
            chk(n, per[i]);
            apb(AUD_IDX_ENABLE, 1'b1, 0);
            q.delete();
        end
        apb(AUD_IDX_OUT_HOLD, 1'b0, 0);
        chk(rd, 32'(AUD_MID_SCALE));
        apb(AUD_IDX_VALID, 1'b0, 0);
        chk(rd, 0);
        apb(AUD_IDX_INTFLAGS, 1'b0, 0);
        chk(rd, 0);
        $display("output rate test done");
        apb(AUD_IDX_ENABLE, 1'b1, 32'h00000010);
        n = 0;
        do
        begin
            apb(AUD_IDX_INTFLAGS, 1'b0, 0);
            n++;
            if (n > 1500)
                bail();
        end
        while (rd[AUD_FL_IN_DONE] !== 1'b1);
        chk(rd, 32'h00000100);
        chk(inDmaData, lastAdc);
        apb(AUD_IDX_VALID, 1'b0, 0);
        chk(rd, 0);
        apb(AUD_IDX_INTFLAGS, 1'b1, 32'h00000E0E);
        apb(AUD_IDX_INTFLAGS, 1'b0, 0);
        chk(rd, 32'h00000100);
        apb(AUD_IDX_INTFLAGS, 1'b1, 32'h00000100);
        apb(AUD_IDX_INTFLAGS, 1'b0, 0);
        chk(rd, 0);
        $display("input flag test done");
        apb(AUD_IDX_ENABLE, 1'b1, 32'h00008011);
        repeat (2) @(posedge mclk);
        chk({outDmaReq, inDmaReq, adcReq}, 0);
        apb(AUD_IDX_VALID, 1'b0, 0);
        chk(rd, 0);
        apb(AUD_IDX_INTFLAGS, 1'b0, 0);
        chk(rd, 0);
        apb(AUD_IDX_ENABLE, 1'b1, 0);
        $display("soft reset test done");
        apb(AUD_IDX_OUT_CTRL, 1'b1, 32'h00008002);
        apb(AUD_IDX_OUT_RATE, 1'b1, 32'(AUD_RATE_44K));
        chk(32'(refEn), 1);
        apb(AUD_IDX_ENABLE, 1'b1, 32'h00000001);
        waitStrobe();
        // input page events must be ignored while that path is off
        pv = 4'hD | 4'(2 * $urandom_range(0, 1));
        pg <= pv;
        @(posedge mclk);
        pg <= 4'h0;
        n = 0;
        do
        begin
            apb(AUD_IDX_INTFLAGS, 1'b0, 0);
            n++;
            if (n > 1500)
                bail();
        end
        while (rd[AUD_FL_OUT_MUTE] !== 1'b1);
        chk(rd, 32'h2 | {pv[1:0], 2'b00});
        chk(outDmaReq, 0);
        apb(AUD_IDX_INTFLAGS, 1'b1, 32'h0000000C);
        // a new strobe shows that requests resumed
        waitStrobe();
        apb(AUD_IDX_ENABLE, 1'b1, 0);
        // enable off first, then the reference
        apb(AUD_IDX_OUT_CTRL, 1'b1, 0);
        q.delete();
        @(posedge mclk);
        chk(32'(refEn), 0);
        $display("page stop test done");
        final_report();
    end
endmodule : aud_converter_control_tb
